//--- blink_timer.sv
// blink phase generator counting frame starts
`timescale 1ns/1ps
module blink_timer
(
   input  wire logic       clock_i,
   input  wire logic       srst_i,
   input  wire logic       frame_i,
   input  wire logic [7:0] period_i,
   output logic            phase_o
);

   typedef struct packed {
      logic [7:0] count;
      logic       phase;
   } blink_state_t;

   blink_state_t state;
   blink_state_t next_state;

   // toggle the phase once every period_i plus one frames
   always_comb
   begin
      next_state = state;
      if (frame_i)
      begin
         if (state.count >= period_i)
         begin
            next_state.count = 8'h00;
            next_state.phase = ~state.phase; // R14
         end
         else
            next_state.count = state.count + 8'h01;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         state <= '0;
      else
         state <= next_state;
   end

   assign phase_o = state.phase;

endmodule

//--- cg_rom_model.sv
// character generator rom model answering the fetch address at once
`timescale 1ns/1ps
module cg_rom_model
(
   input  wire logic [11:0]         cg_addr_i,
   output char_video_pkg::cg_word_t cg_data_o
);
   // code above, scan row in the low four bits; code msb marks graphics
   assign cg_data_o = {cg_addr_i[10:4] ^ {3'h0, cg_addr_i[3:0]}, cg_addr_i[11]};
endmodule

//--- char_dot_video.sv
// character dot video generator: word forming, attributes, two-level output
//
// Contract
// [R01] each character fetch loads its dot word into a shift register, shifted serially
// [R02] normal characters show blank first and last dots on every scan line; the code lights all nine dots on an underlined bottom row
// [R03] graphics characters copy the second dot into the first dot
// [R04] normal word: blank, pattern leftmost to rightmost, blank, flag clear
// [R05] graphics word: leftmost repeated first, rightmost repeated last, flag set
// [R06] top scan row blank unless graphics character
// [R07] bottom scan row blank unless graphics or underlined
// [R08] rows one to ten carry the character dot matrix
// [R09] attributes load with the dots into a final register, constant for the line
// [R10] field emulation holds attributes from one delimiter to the next
// [R11] half intensity attribute selects the lower video level
// [R12] inverse complements dots after character and scan line blanking
// [R13] blank attribute leaves only background for the cell
// [R14] blink alternates normal and blanked at a programmed rate
// [R15] output is two-level: half or full intensity per dot
// [R16] lowest four generator address bits are the scan line number
// [R17] display word: five attributes, size, protect, national, eight-bit code
// [R18] matrix up to seven by ten inside a nine by twelve cell
// [R19] one dot per clock, reload every nine clocks while not blanking
// [R20] during blanking video is black regardless of attributes
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module char_dot_video
(
   input  wire logic                             clock_i,
   input  wire logic                             srst_i,
   input  wire logic                             blank_i,
   input  wire logic                             frame_i,
   input  wire logic [3:0]                       scan_line_i,
   input  wire char_video_pkg::disp_word_t       disp_word_i,
   input  wire char_video_pkg::cg_word_t         cg_data_i,
   input  wire char_video_pkg::reg_req_t         reg_req_i,
   output logic [11:0]                           cg_addr_o,
   output logic                                  char_next_o,
   output logic                                  dot_o,
   output logic                                  half_o,
   output logic [31:0]                           reg_rdata_o
);

   typedef struct packed {
      logic [3:0]             dot_cnt;
      logic [11:0]            cg_addr;
      char_video_pkg::attr_t  stage_attr;
      logic                   stage_delim;
      char_video_pkg::attr_t  hold_attr;
      char_video_pkg::attr_t  final_attr;
      logic                   final_gfx;
      logic                   char_next;
      logic                   blank_q;
      logic                   dot;
      logic                   half;
      logic                   emul_en;
      logic [7:0]             blink_period;
      logic [31:0]            rdata;
   } video_state_t;

   video_state_t state;
   video_state_t next_state;

   logic       load;
   logic       shift_dot;
   logic [8:0] line_word;
   logic       raw_dot;
   logic       blink_phase;

   // build one scan line of a cell from the generator pattern
   function automatic logic [8:0] form_line
   (
      input char_video_pkg::cg_word_t cg,
      input logic [3:0]               row,
      input logic                     underline
   );
      logic [8:0] word;
      word = '0;
      if (cg.graphics_flag_bit)
         word = {cg.pattern[6], cg.pattern, cg.pattern[0]};        // R03 R05
      else
         word = {1'b0, cg.pattern, 1'b0};                          // R02 R04
      if (!cg.graphics_flag_bit)
      begin
         if (row == char_video_pkg::TOP_ROW)
            word = '0;                                             // R06
         else if (row == char_video_pkg::BOTTOM_ROW)
            word = underline ? '1 : '0;                            // R07
         else if (row > char_video_pkg::BOTTOM_ROW)
            word = '0;                                             // R18
      end
      return word;                                                 // R08
   endfunction

   // register-port decode, used for both strobes
   function automatic logic hits
   (
      input logic [3:0] addr,
      input logic [3:0] offset
   );
      return addr == offset;
   endfunction

   // dot timing: reload on the last dot position while not blanking
   assign load      = !blank_i && (state.dot_cnt == char_video_pkg::LAST_DOT); // R19
   assign shift_dot = !blank_i && !load;
   assign line_word = form_line(cg_data_i, scan_line_i, state.stage_attr.underline);

   dot_shifter u_shifter
   (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .load_i  (load),
      .shift_i (shift_dot),
      .word_i  (line_word),
      .dot_o   (raw_dot)
   );

   blink_timer u_blink
   (
      .clock_i  (clock_i),
      .srst_i   (srst_i),
      .frame_i  (frame_i),
      .period_i (state.blink_period),
      .phase_o  (blink_phase)
   );

   // next-state logic for counters, pipeline, video and registers
   always_comb
   begin
      logic                  lit;
      char_video_pkg::attr_t eff_attr;
      lit      = 1'b0;
      eff_attr = '0;
      next_state           = state;
      next_state.char_next = 1'b0;
      next_state.blank_q   = blank_i;

      // dot position counter, parked at the last dot during blanking
      if (blank_i)
         next_state.dot_cnt = char_video_pkg::LAST_DOT;            // R19
      else if (load)
         next_state.dot_cnt = 4'h0;
      else
         next_state.dot_cnt = state.dot_cnt + 4'h1;

      // fetch stage: generator address and attributes of the next character
      if (blank_i || state.dot_cnt == char_video_pkg::FETCH_DOT)
      begin
         next_state.cg_addr = {disp_word_i.code, scan_line_i};     // R16 R17
         next_state.stage_delim = (disp_word_i.code == char_video_pkg::DELIM_CODE);
         if (state.emul_en)
         begin
            if (disp_word_i.code == char_video_pkg::DELIM_CODE)
            begin
               next_state.hold_attr  = disp_word_i.attr;           // R10
               next_state.stage_attr = disp_word_i.attr;
            end
            else
               next_state.stage_attr = state.hold_attr;            // R10
         end
         else
            next_state.stage_attr = disp_word_i.attr;
      end

      // final pipeline register loads together with the dots
      if (load)
      begin
         next_state.final_attr = state.stage_attr;                 // R09
         next_state.final_gfx  = cg_data_i.graphics_flag_bit;
         next_state.char_next  = 1'b1;                             // R01
      end

      // dot shaping: suppress, then invert, then force black in blanking
      eff_attr = state.final_attr;
      lit      = raw_dot;
      if (eff_attr.blank || (eff_attr.blink && blink_phase))
         lit = 1'b0;                                               // R13 R14
      if (eff_attr.inverse)
         lit = ~lit;                                               // R12
      if (state.blank_q)
      begin
         next_state.dot  = 1'b0;                                   // R20
         next_state.half = 1'b0;
      end
      else
      begin
         next_state.dot  = lit;                                    // R15
         next_state.half = eff_attr.half;                          // R11
      end

      // register port: writes steer the block, reads show its state
      next_state.rdata = 32'h0000_0000;
      if (reg_req_i.wr && hits(reg_req_i.addr, char_video_pkg::CTRL_OFFSET))
      begin
         next_state.emul_en      = reg_req_i.wdata[char_video_pkg::CTRL_EMUL_POS];
         next_state.blink_period = reg_req_i.wdata[char_video_pkg::CTRL_BLINK_LSB +: 8];
      end
      if (reg_req_i.rd)
      begin
         if (hits(reg_req_i.addr, char_video_pkg::CTRL_OFFSET))
         begin
            next_state.rdata[char_video_pkg::CTRL_EMUL_POS]       = state.emul_en;
            next_state.rdata[char_video_pkg::CTRL_BLINK_LSB +: 8] = state.blink_period;
         end
         else if (hits(reg_req_i.addr, char_video_pkg::STATUS_OFFSET))
         begin
            next_state.rdata[char_video_pkg::STAT_PHASE_POS]     = blink_phase;
            next_state.rdata[char_video_pkg::STAT_ATTR_LSB +: 5] = state.final_attr;
            next_state.rdata[char_video_pkg::STAT_GFX_POS]       = state.final_gfx;
         end
      end
   end

   // state register
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         state              <= '0;
         state.dot_cnt      <= char_video_pkg::LAST_DOT;
         state.blank_q      <= 1'b1;
         state.blink_period <= char_video_pkg::BLINK_RESET;
      end
      else
         state <= next_state;
   end

   // outputs straight from the state register
   assign cg_addr_o   = state.cg_addr;
   assign char_next_o = state.char_next;
   assign dot_o       = state.dot;
   assign half_o      = state.half;
   assign reg_rdata_o = state.rdata;

endmodule

//--- char_dot_video_asserts.sv
// assertion checker for the character dot video generator ports
`timescale 1ns/1ps
module char_dot_video_asserts
(
   input wire logic                       clock_i,
   input wire logic                       srst_i,
   input wire logic                       blank_i,
   input wire logic                       frame_i,
   input wire logic [3:0]                 scan_line_i,
   input wire char_video_pkg::disp_word_t disp_word_i,
   input wire char_video_pkg::cg_word_t   cg_data_i,
   input wire char_video_pkg::reg_req_t   reg_req_i,
   input wire logic [11:0]                cg_addr_o,
   input wire logic                       char_next_o,
   input wire logic                       dot_o,
   input wire logic                       half_o,
   input wire logic [31:0]                reg_rdata_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);
   logic [8:0] ctrl_seen;

   // shadow of blink period and emulation enable
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         ctrl_seen <= 9'h010;
      else if (reg_req_i.wr && reg_req_i.addr == char_video_pkg::CTRL_OFFSET)
         ctrl_seen <= {reg_req_i.wdata[11:4], reg_req_i.wdata[0]};
   end

   // a load followed by eight unblanked cycles
   sequence full_line;
      (char_next_o && !blank_i) ##1 !blank_i [*8];
   endsequence

   chk_blank_dark: assert property (blank_i |-> ##2 (!dot_o && !half_o))
      else $error("video lit during blanking");
   chk_no_load: assert property (blank_i |=> !char_next_o)
      else $error("load during blanking");
   chk_load_period: assert property (full_line |=> char_next_o)
      else $error("reload not nine dots apart");
   chk_attr_hold: assert property (full_line |=> $stable(half_o) && half_o == $past(half_o, 8))
      else $error("intensity changed within a cell");
   chk_cg_address: assert property (blank_i |=> cg_addr_o == {$past(disp_word_i.code), $past(scan_line_i)})
      else $error("generator address wrong");
   chk_rdata_idle: assert property (!reg_req_i.rd |=> reg_rdata_o == 32'h0)
      else $error("read data outside its slot");
   chk_unmapped_read: assert property (reg_req_i.rd && reg_req_i.addr[1:0] != 2'h0 |=> reg_rdata_o == 32'h0)
      else $error("unmapped read not zero");
   chk_ctrl_read: assert property (reg_req_i.rd && reg_req_i.addr == char_video_pkg::CTRL_OFFSET
      |=> reg_rdata_o == {20'h0, ctrl_seen[8:1], 3'h0, ctrl_seen[0]})
      else $error("control readback wrong");

   // main scenarios reached
   cover property (full_line);
   cover property (reg_req_i.rd ##1 reg_rdata_o != 32'h0);
   cover property ($fell(blank_i) ##2 dot_o);
endmodule
bind char_dot_video char_dot_video_asserts char_dot_video_asserts_inst (.clock_i, .srst_i, .blank_i, .frame_i,
   .scan_line_i, .disp_word_i, .cg_data_i, .reg_req_i, .cg_addr_o, .char_next_o, .dot_o, .half_o, .reg_rdata_o);

//--- char_video_pkg.sv
// shared constants and carrier types for the character dot video generator
package char_video_pkg;

   // character cell geometry
   localparam int unsigned CELL_DOTS       = 9;
   localparam int unsigned PATTERN_BITS    = 7;
   localparam int unsigned SCAN_BITS       = 4;
   localparam int unsigned CODE_BITS       = 8;
   localparam int unsigned CG_ADDR_BITS    = CODE_BITS + SCAN_BITS;
   localparam logic [3:0]  LAST_DOT        = 4'h8;
   localparam logic [3:0]  FETCH_DOT       = 4'h7;
   localparam logic [3:0]  TOP_ROW         = 4'h0;
   localparam logic [3:0]  BOTTOM_ROW      = 4'hB;

   // field attribute delimiter character code
   localparam logic [7:0]  DELIM_CODE      = 8'h1E;

   // register port
   localparam int unsigned REG_ADDR_BITS   = 4;
   localparam logic [3:0]  CTRL_OFFSET     = 4'h0;
   localparam logic [3:0]  STATUS_OFFSET   = 4'h4;
   localparam int unsigned CTRL_EMUL_POS   = 0;
   localparam int unsigned CTRL_BLINK_LSB  = 4;
   localparam int unsigned STAT_PHASE_POS  = 0;
   localparam int unsigned STAT_ATTR_LSB   = 1;
   localparam int unsigned STAT_GFX_POS    = 6;
   localparam logic [7:0]  BLINK_RESET     = 8'h08;

   // per-character attribute bits, display word bits 15..11
   typedef struct packed {
      logic underline;
      logic blink;
      logic blank;
      logic inverse;
      logic half;
   } attr_t;

   // one display memory word
   typedef struct packed {
      attr_t      attr;
      logic       size;
      logic       protect;
      logic       national;
      logic [7:0] code;
   } disp_word_t;

   // character generator output
   typedef struct packed {
      logic [6:0] pattern;
      logic       graphics_flag_bit;
   } cg_word_t;

   // register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

endpackage

//--- dot_shifter.sv
// nine-dot serialiser for one character scan line
`timescale 1ns/1ps
module dot_shifter
(
   input  wire logic       clock_i,
   input  wire logic       srst_i,
   input  wire logic       load_i,
   input  wire logic       shift_i,
   input  wire logic [8:0] word_i,
   output logic            dot_o
);

   typedef struct packed {
      logic [8:0] sr;
      logic       dot;
   } shift_state_t;

   shift_state_t state;
   shift_state_t next_state;

   // load wins over shift; dots leave msb first
   always_comb
   begin
      next_state = state;
      if (load_i)
      begin
         next_state.sr  = {word_i[7:0], 1'b0}; // R01
         next_state.dot = word_i[8];
      end
      else if (shift_i)
      begin
         next_state.dot = state.sr[8];         // R19
         next_state.sr  = {state.sr[7:0], 1'b0};
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         state <= '0;
      else
         state <= next_state;
   end

   assign dot_o = state.dot;

endmodule

//--- tb_char_dot_video.sv
// self-checking testbench for the character dot video generator
`timescale 1ns/1ps
module tb_char_dot_video;
   logic                       clock_i;
   logic                       srst_i;
   logic                       blank_i;
   logic                       frame_i;
   logic [3:0]                 scan_line_i;
   char_video_pkg::disp_word_t disp_word_i;
   char_video_pkg::cg_word_t   cg_data_i;
   char_video_pkg::reg_req_t   reg_req_i;
   logic [11:0]                cg_addr_o;
   logic                       char_next_o;
   logic                       dot_o;
   logic                       half_o;
   logic [31:0]                reg_rdata_o;
   int                         mismatches;
   int                         n_compared;

   char_dot_video char_dot_video_inst (.clock_i, .srst_i, .blank_i, .frame_i, .scan_line_i, .disp_word_i,
      .cg_data_i, .reg_req_i, .cg_addr_o, .char_next_o, .dot_o, .half_o, .reg_rdata_o);
   cg_rom_model cg_rom_model_inst (.cg_addr_i(cg_addr_o), .cg_data_o(cg_data_i));

   // 100 MHz dot clock
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_req_i <= {a, d, 2'b10};
      @(posedge clock_i);
      reg_req_i <= '0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock_i);
      reg_req_i <= {a, 32'h0, 2'b01};
      @(posedge clock_i);
      reg_req_i <= '0;
      #1;
      d = reg_rdata_o;
   endtask

   // expected dots of one cell line
   function automatic logic [8:0] line(input char_video_pkg::disp_word_t w, input logic [3:0] r, input logic ph);
      logic [6:0] p;
      logic [8:0] v;
      p = w.code[6:0] ^ {3'h0, r};
      v = w.code[7] ? {p[6], p, p[0]} : {1'b0, p, 1'b0};
      if (!w.code[7] && (r == 4'h0 || r >= 4'hB)) v = (r == 4'hB && w.attr.underline) ? 9'h1FF : 9'h0;
      if (w.attr.blank || (w.attr.blink && ph)) v = 9'h0;
      if (w.attr.inverse) v = ~v;
      return v;
   endfunction

   // one unblanked line of a cell, nine dots captured
   task automatic show(input char_video_pkg::disp_word_t w, input logic [3:0] r, output logic [8:0] d,
                       output logic h);
      int n;
      @(posedge clock_i);
      disp_word_i <= w;
      scan_line_i <= r;
      @(posedge clock_i);
      blank_i <= 1'b0;
      for (n = 0; n < 20 && char_next_o !== 1'b1; n++)
      begin
         @(posedge clock_i);
         #1;
      end
      if (n == 20)
      begin
         mismatches++;
         give_verdict();
      end
      for (int i = 8; i >= 0; i--)
      begin
         @(posedge clock_i);
         #1;
         d[i] = dot_o;
         h = half_o;
      end
      @(posedge clock_i);
      blank_i <= 1'b1;
   endtask

   task automatic t_regs();
      logic [31:0] v;
      reg_rd(char_video_pkg::CTRL_OFFSET, v);
      check(v, 32'h80);
      reg_rd(char_video_pkg::STATUS_OFFSET, v);
      check(v, 32'h0);
      reg_wr(4'h8, 32'hFFFF_FFFF);
      reg_rd(4'h8, v);
      check(v, 32'h0);
      reg_rd(4'h9, v);
      check(v, 32'h0);
      reg_rd(char_video_pkg::CTRL_OFFSET, v);
      check(v, 32'h80);
   endtask

   task automatic t_rows();
      logic [8:0]  d;
      logic        h;
      logic [15:0] w [3] = '{16'h0041, 16'h00C5, 16'h8041};
      for (int r = 0; r < 12; r++)
         for (int k = 0; k < 3; k++)
         begin
            show(w[k], 4'(r), d, h);
            check(d, line(w[k], 4'(r), 1'b0));
         end
      show(w[0], 4'hC, d, h);
      check(d, line(w[0], 4'hC, 1'b0));
   endtask

   task automatic t_attrs();
      logic [8:0]  d;
      logic        h;
      logic [15:0] w [4] = '{16'h1041, 16'h2041, 16'h3041, 16'h0841};
      for (int k = 0; k < 4; k++)
      begin
         show(w[k], 4'h5, d, h);
         check(d, line(w[k], 4'h5, 1'b0));
         check(h, w[k][11]);
      end
   endtask

   task automatic t_dark();
      logic [8:0] d;
      logic       h;
      show(16'h1841, 4'h0, d, h);
      check(d, line(16'h1841, 4'h0, 1'b0));
      // dots lag blanking by the blank_q stage and the output register
      repeat (2) @(posedge clock_i);
      #1;
      check({dot_o, half_o}, 2'b00);
   endtask

   task automatic t_field();
      logic [8:0] d;
      logic       h;
      reg_wr(char_video_pkg::CTRL_OFFSET, 32'h81);
      show(16'h101E, 4'h3, d, h);
      check(d, line(16'h101E, 4'h3, 1'b0));
      show(16'h0041, 4'h3, d, h);
      check(d, line(16'h1041, 4'h3, 1'b0));
      reg_wr(char_video_pkg::CTRL_OFFSET, 32'h80);
      show(16'h0041, 4'h3, d, h);
      check(d, line(16'h0041, 4'h3, 1'b0));
   endtask

   task automatic t_blink();
      logic [8:0]  d;
      logic        h;
      logic [31:0] v;
      reg_wr(char_video_pkg::CTRL_OFFSET, 32'h10);
      // the phase turns on the frame after the count reaches the period
      repeat (2)
      begin
         @(posedge clock_i);
         frame_i <= 1'b1;
         @(posedge clock_i);
         frame_i <= 1'b0;
      end
      show(16'h4041, 4'h5, d, h);
      check(d, line(16'h4041, 4'h5, 1'b1));
      reg_rd(char_video_pkg::STATUS_OFFSET, v);
      check(v, 32'h11);
   endtask

   // reset, then the scenarios in turn
   initial
   begin
      mismatches = 0;
      n_compared = 0;
      srst_i = 1'b1;
      blank_i = 1'b1;
      frame_i = 1'b0;
      scan_line_i = 4'h0;
      disp_word_i = '0;
      reg_req_i = '0;
      repeat (10) @(posedge clock_i);
      srst_i <= 1'b0;
      t_regs();
      t_rows();
      t_attrs();
      t_dark();
      t_field();
      t_blink();
      give_verdict();
   end
endmodule
